// ==== src/mps_sequencer.sv ====
// Microprogram phase sequencer with fetch-phase control
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [7:0]                 condIn,
  input  wire logic                       skipTest,
  input  wire logic                       intReq,
  input  wire logic [15:0]                pc,
  input  wire logic [15:0]                memData,
  input  wire logic [15:0]                accA,
  input  wire logic [15:0]                accB,
  input  wire logic [8:0]                 execEntry,
  input  wire logic                       loadEn,
  input  wire logic [8:0]                 loadAddr,
  input  wire logic [23:0]                loadData,
  output logic [8:0]                      upc,
  output logic [23:0]                     execWord,
  output logic                            stalled,
  output logic [1:0]                      phase,
  output logic                            setPhase,
  output logic [15:0]                     memAddr,
  output logic                            memStart,
  output logic                            abAddr,
  output logic [15:0]                     instrReg,
  output logic [15:0]                     scratchOne,
  output logic                            decIoEn,
  output logic                            decShiftEn,
  output logic                            decSkipEn
);
  mps_pkg::mps_seq_e   seq;
  mps_pkg::mps_phase_e curPhase;
  logic [23:0] word;
  logic [8:0]  next_upc;
  logic [8:0]  retAddr;
  logic        eopArmed;
  logic        abUseB;

  // Field split of the word now at the head of the pipe
  logic [2:0] fCond;
  logic [4:0] fFn;
  logic [3:0] fSpec;
  logic [3:0] fSkip;
  assign fCond = word[mps_pkg::COND_LSB +: 3];
  assign fFn   = word[mps_pkg::FN_LSB +: 5];
  assign fSpec = word[mps_pkg::SPEC_LSB +: 4];
  assign fSkip = word[mps_pkg::SKIP_LSB +: 4];

  // A word runs only once its condition holds; none never waits
  logic condOk;
  logic run;
  assign condOk = (fCond == mps_pkg::COND_NONE) || condIn[fCond];
  assign run = (seq == mps_pkg::SQ_RUN) && condOk;

  // Fetch step decode
  logic inFetch;
  logic fetch0;
  logic fetch1;
  logic fetch2;
  assign inFetch = (curPhase == mps_pkg::PH_FETCH);
  assign fetch0 = run && inFetch && (upc == mps_pkg::FETCH_ADDR0);
  assign fetch1 = run && inFetch && (upc == mps_pkg::FETCH_ADDR1);
  assign fetch2 = run && inFetch && (upc == mps_pkg::FETCH_ADDR2);

  // Instruction source: A/B when the fetch address hit an accumulator
  logic [15:0] irSrc;
  logic        memRefNext;
  assign irSrc = abAddr ? (abUseB ? accB : accA) : memData;
  assign memRefNext = (irSrc[14:12] != 3'h0);

  // Ending step flags; a skip never hides the end-of-phase code
  logic eopHere;
  logic skipHere;
  logic endPhase;
  assign eopHere = run && (fSkip == mps_pkg::SK_EOP);
  assign skipHere = run && ((fSkip == mps_pkg::SK_TEST && skipTest)
                    || (fetch1 && !memRefNext));
  assign endPhase = run && (eopArmed || (eopHere && skipHere));

  // Set-phase lookup: present phase, interrupt and instruction class
  function automatic mps_pkg::mps_phase_e lookupPhase(
    input mps_pkg::mps_phase_e cur,
    input logic                irq,
    input logic [15:0]         ir
  );
    mps_pkg::mps_phase_e nxt;
    nxt = mps_pkg::PH_FETCH;
    case (cur)
      mps_pkg::PH_FETCH: begin
        if (irq) begin
          nxt = mps_pkg::PH_INTR;
        end else if (ir[15] && ir[14:12] != 3'h0) begin
          nxt = mps_pkg::PH_INDIR;
        end else begin
          nxt = mps_pkg::PH_EXEC;
        end
      end
      mps_pkg::PH_INDIR: nxt = mps_pkg::PH_EXEC;
      mps_pkg::PH_INTR:  nxt = mps_pkg::PH_EXEC;
      mps_pkg::PH_EXEC:  nxt = irq ? mps_pkg::PH_INTR : mps_pkg::PH_FETCH;
      default:           nxt = mps_pkg::PH_FETCH;
    endcase
    return nxt;
  endfunction : lookupPhase

  // The instruction register may be loaded in this very step
  logic [15:0] irView;
  mps_pkg::mps_phase_e newPhase;
  logic [8:0] entry;
  assign irView = fetch1 ? irSrc : instrReg;
  assign newPhase = lookupPhase(curPhase, intReq, irView);
  always_comb begin
    case (newPhase)
      mps_pkg::PH_FETCH: entry = mps_pkg::FETCH_ADDR0;
      mps_pkg::PH_INDIR: entry = mps_pkg::ENTRY_INDIR;
      mps_pkg::PH_INTR:  entry = mps_pkg::ENTRY_INTR;
      default:           entry = execEntry;
    endcase
  end

  // Next micro address; the ROM read register returns it next cycle
  always_comb begin
    next_upc = upc;
    if (seq == mps_pkg::SQ_PRIME) begin
      next_upc = upc;
    end else if (!run) begin
      next_upc = upc;
    end else if (endPhase) begin
      next_upc = entry;
    end else if (fFn == mps_pkg::FN_JUMP || fFn == mps_pkg::FN_JSUB) begin
      next_upc = word[8:0];
    end else if (fFn == mps_pkg::FN_RET) begin
      next_upc = retAddr;
    end else if (skipHere) begin
      next_upc = upc + 9'h002;
    end else begin
      next_upc = upc + 9'h001;
    end
  end

  mps_rom u_rom (
    .core_clk (core_clk),
    .rdAddr   (next_upc),
    .rdData   (word),
    .wrEn     (loadEn),
    .wrAddr   (loadAddr),
    .wrData   (loadData)
  );

  // Sequencer state; one priming cycle fills the ROM read register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq <= mps_pkg::SQ_PRIME;
      upc <= mps_pkg::FETCH_ADDR0;
    end else begin
      case (seq)
        mps_pkg::SQ_PRIME: seq <= mps_pkg::SQ_RUN;
        mps_pkg::SQ_RUN:   seq <= mps_pkg::SQ_RUN;
        default:           seq <= mps_pkg::SQ_PRIME;
      endcase
      upc <= next_upc;
    end
  end

  // Return address for subroutine jumps
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retAddr <= 9'h000;
    end else if (run && fFn == mps_pkg::FN_JSUB) begin
      retAddr <= upc + 9'h001;
    end
  end

  // Phase logic: armed by end-of-phase, switched after the last word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      curPhase <= mps_pkg::PH_FETCH;
      eopArmed <= 1'b0;
      setPhase <= 1'b0;
    end else begin
      setPhase <= eopHere;
      if (endPhase) begin
        curPhase <= newPhase;
        eopArmed <= 1'b0;
      end else if (eopHere) begin
        eopArmed <= 1'b1;
      end
    end
  end
  assign phase = curPhase;

  // Status outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      execWord <= 24'h000000;
      stalled  <= 1'b0;
    end else begin
      stalled <= (seq == mps_pkg::SQ_RUN) && !condOk;
      if (run) begin
        execWord <= word;
      end
    end
  end

  // Fetch data path: memory address, A/B test, IR and scratch one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memAddr    <= mps_pkg::WORD16_RESET;
      memStart   <= 1'b0;
      abAddr     <= 1'b0;
      abUseB     <= 1'b0;
      instrReg   <= mps_pkg::WORD16_RESET;
      scratchOne <= mps_pkg::WORD16_RESET;
    end else begin
      memStart <= fetch0 || (run && fSpec == mps_pkg::SP_RW);
      if (fetch0) begin
        memAddr <= pc;
        abAddr  <= (pc[14:1] == 14'h0000);
        abUseB  <= pc[0];
      end else if (fetch2) begin
        scratchOne <= {pc[15:10], instrReg[9:0]};
        abAddr     <= ({pc[14:10], instrReg[9:1]} == 14'h0000);
        abUseB     <= instrReg[0];
      end
      if (fetch1) begin
        instrReg <= irSrc;
      end
    end
  end

  // Hardware group decoder enables, one pulse per enabling word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      decIoEn    <= 1'b0;
      decShiftEn <= 1'b0;
      decSkipEn  <= 1'b0;
    end else begin
      decIoEn    <= run && fSpec == mps_pkg::SP_DEC_IO;
      decShiftEn <= run && fSpec == mps_pkg::SP_DEC_SR;
      decSkipEn  <= run && fSpec == mps_pkg::SP_DEC_AS;
    end
  end

  // Checks
  a_stall_holds_pc:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (seq == mps_pkg::SQ_RUN && !condOk) |=> (upc == $past(upc)))
    else $error("upc moved while condition false");
  a_none_no_stall:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (seq == mps_pkg::SQ_RUN && fCond == mps_pkg::COND_NONE) |=> !stalled)
    else $error("stall on unconditional word");
  a_eop_sets_phase:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    eopHere |=> setPhase)
    else $error("end of phase did not enable set-phase");
  a_fetch_order:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    fetch0 |=> (upc == mps_pkg::FETCH_ADDR1))
    else $error("fetch step 001 does not follow 000");
  a_fetch_addr:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    fetch0 |=> (memStart && memAddr == $past(pc)))
    else $error("fetch did not address memory from pc");
  a_ir_load:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    fetch1 |=> (instrReg == $past(irSrc)))
    else $error("instruction register not loaded");
  a_skip_nonmem:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (fetch1 && !memRefNext) |=> (upc != mps_pkg::FETCH_ADDR2))
    else $error("step 002 not skipped");
  a_operand_addr:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    fetch2 |=> (scratchOne[9:0] == $past(instrReg[9:0])))
    else $error("operand address not formed");
  a_jump_target:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (run && !endPhase && fFn == mps_pkg::FN_JUMP)
      |=> (upc == $past(word[8:0])))
    else $error("jump target not taken");
  a_decoder_pulse:
  assert property (@(posedge core_clk) disable iff (!rst_b)
    (run && fSpec == mps_pkg::SP_DEC_IO) |=> decIoEn)
    else $error("I/O decoder enable missing");
endmodule : mps_sequencer
`default_nettype wire

// ==== src/mps_pkg.sv ====
// Shared constants for the microprogram phase sequencer
package mps_pkg;
  // Microword layout, one 24-bit control store word
  localparam int WORD_W    = 24;
  localparam int ADDR_W    = 9;
  localparam int COND_LSB  = 21; // 3 bits, execution condition select
  localparam int SRC_LSB   = 17; // 4 bits, bus source
  localparam int FN_LSB    = 12; // 5 bits, function
  localparam int STORE_LSB = 8;  // 4 bits, store destination
  localparam int SPEC_LSB  = 4;  // 4 bits, special
  localparam int SKIP_LSB  = 0;  // 4 bits, skip
  localparam int ROM_DEPTH = 512;

  // Condition select: zero means none
  localparam logic [2:0] COND_NONE = 3'h0;
  localparam logic [2:0] COND_MEMRDY = 3'h1;

  // Function codes; jump, subroutine jump and return have sequencing effects
  localparam logic [4:0] FN_JUMP = 5'h01; // jump_code
  localparam logic [4:0] FN_JSUB = 5'h02; // jump_to_subroutine
  localparam logic [4:0] FN_RET  = 5'h03;
  localparam logic [4:0] FN_IOR  = 5'h04;

  // Special codes
  localparam logic [3:0] SP_NONE   = 4'h0;
  localparam logic [3:0] SP_DEC_IO = 4'h1;
  localparam logic [3:0] SP_DEC_SR = 4'h2;
  localparam logic [3:0] SP_DEC_AS = 4'h3;
  localparam logic [3:0] SP_RW     = 4'h4;

  // Skip codes
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_EOP  = 4'h1; // end_of_phase_code
  localparam logic [3:0] SK_TEST = 4'h2; // skip next when skip test true

  // Fixed fetch microcode at 000..002
  localparam logic [ADDR_W-1:0] FETCH_ADDR0 = 9'h000;
  localparam logic [ADDR_W-1:0] FETCH_ADDR1 = 9'h001;
  localparam logic [ADDR_W-1:0] FETCH_ADDR2 = 9'h002;
  localparam logic [WORD_W-1:0] FETCH_WORD0 = 24'h024140;
  localparam logic [WORD_W-1:0] FETCH_WORD1 = 24'h244201;
  localparam logic [WORD_W-1:0] FETCH_WORD2 = 24'h064300;

  // Phase entry points other than fetch and execute
  localparam logic [ADDR_W-1:0] ENTRY_INTR  = 9'h004;
  localparam logic [ADDR_W-1:0] ENTRY_INDIR = 9'h008;

  // Phases, Gray coded along fetch -> indirect -> execute -> interrupt
  typedef enum logic [1:0] {
    PH_FETCH = 2'h0,
    PH_INDIR = 2'h1,
    PH_EXEC  = 2'h3,
    PH_INTR  = 2'h2
  } mps_phase_e;

  // Sequencer state
  typedef enum logic [1:0] {
    SQ_PRIME = 2'h0,
    SQ_RUN   = 2'h1
  } mps_seq_e;

  // Reset values
  localparam logic [15:0] WORD16_RESET = 16'h0000;
endpackage : mps_pkg

// ==== src/mps_rom.sv ====
// Control store: fixed fetch words plus a loadable microcode array
`timescale 1ns/1ns
`default_nettype none
module mps_rom (
  input  wire logic                         core_clk,
  input  wire logic [mps_pkg::ADDR_W-1:0]   rdAddr,
  output var  logic [mps_pkg::WORD_W-1:0]   rdData,
  input  wire logic                         wrEn,
  input  wire logic [mps_pkg::ADDR_W-1:0]   wrAddr,
  input  wire logic [mps_pkg::WORD_W-1:0]   wrData
);
  logic [mps_pkg::WORD_W-1:0] store [mps_pkg::ROM_DEPTH];

  // Loading; the fetch words are hard-wired so cannot be overwritten
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge core_clk) begin
    case (rdAddr)
      mps_pkg::FETCH_ADDR0: rdData <= mps_pkg::FETCH_WORD0;
      mps_pkg::FETCH_ADDR1: rdData <= mps_pkg::FETCH_WORD1;
      mps_pkg::FETCH_ADDR2: rdData <= mps_pkg::FETCH_WORD2;
      default:              rdData <= store[rdAddr];
    endcase
  end
endmodule : mps_rom
`default_nettype wire

// ==== verification/mps_mem_model.sv ====
// Core memory model answering the sequencer's read-write cycles
`timescale 1ns/1ns
`default_nettype none
module mps_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        memStart,
  input  wire logic [2:0]  delay,
  input  wire logic [15:0] word,
  output logic             memReady,
  output logic [15:0]      memData
);
  logic [2:0] cnt;
  logic       ready;

  // Ready drops on every start and returns after the chosen delay
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt   <= 3'h0;
      ready <= 1'b0;
    end else if (memStart) begin
      cnt   <= delay;
      ready <= 1'b0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else begin
      ready <= 1'b1;
    end
  end

  // Masked by start so a stale ready never lets a word run early
  assign memReady = ready & ~memStart;
  // Data is not valid before ready: show the inverse, not the last value
  assign memData = memReady ? word : ~word;
endmodule : mps_mem_model
`default_nettype wire

// ==== verification/test_microprogram_phase_sequencer.sv ====
// Self-checking bench for the phase sequencer and fetch control
`timescale 1ns/1ns
`default_nettype none
module test_microprogram_phase_sequencer;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        skipTest = 1'b0, intReq = 1'b0, loadEn = 1'b0;
  logic [15:0] pc = 16'h0000, accA = 16'h0000, accB = 16'h0000;
  logic [15:0] word = 16'h0000, memData, instrReg, scratchOne, memAddr;
  logic [8:0]  loadAddr = 9'h000, upc;
  logic [23:0] loadData = 24'h000000, execWord;
  logic [7:0]  condIn;
  logic [2:0]  delay = 3'h0;
  logic [1:0]  phase;
  logic        memReady, stalled, setPhase, memStart, abAddr;
  logic        decIoEn, decShiftEn, decSkipEn;
  logic [31:0] r;
  logic [15:0] expIr, expSc;
  logic [1:0]  expPh;
  int          seed = 5, n_errors = 0, n_tests = 0, cntIo, cntSr, cntAs, i;
  // Microcode for the other phases: jump, three decoders, end of phase
  logic [8:0]  romA [9] = '{9'h004, 9'h005, 9'h008, 9'h009, 9'h010,
                            9'h011, 9'h014, 9'h015, 9'h016};
  logic [23:0] romD [9] = '{24'h000001, 24'h000000, 24'h000001,
                            24'h000000, 24'h001014, 24'h000010,
                            24'h000020, 24'h000031, 24'h000000};

  always #25 core_clk = ~core_clk;
  assign condIn = {6'h00, memReady, 1'b0};

  mps_mem_model mem (.core_clk(core_clk), .rst_b(rst_b), .memStart(memStart),
    .delay(delay), .word(word), .memReady(memReady), .memData(memData));

  mps_sequencer dut (.core_clk(core_clk), .rst_b(rst_b), .condIn(condIn),
    .skipTest(skipTest), .intReq(intReq), .pc(pc), .memData(memData),
    .accA(accA), .accB(accB), .execEntry(9'h010), .loadEn(loadEn),
    .loadAddr(loadAddr), .loadData(loadData), .upc(upc),
    .execWord(execWord), .stalled(stalled), .phase(phase),
    .setPhase(setPhase), .memAddr(memAddr), .memStart(memStart),
    .abAddr(abAddr), .instrReg(instrReg), .scratchOne(scratchOne),
    .decIoEn(decIoEn), .decShiftEn(decShiftEn), .decSkipEn(decSkipEn));

  // Decoder pulses counted per instruction; the bench clears them
  always @(posedge core_clk) begin
    if (decIoEn === 1'b1) cntIo++;
    if (decShiftEn === 1'b1) cntSr++;
    if (decSkipEn === 1'b1) cntAs++;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  function automatic logic hit(input int w);
    case (w)
      0:       hit = (memStart === 1'b1);
      1:       hit = (setPhase === 1'b1);
      2:       hit = (phase !== mps_pkg::PH_FETCH);
      default: hit = (phase === mps_pkg::PH_FETCH);
    endcase
  endfunction : hit

  // Bounded wait; a wait that runs out is a mismatch of its own
  task automatic wait_for(input int w);
    for (i = 0; i < 60 && !hit(w); i++) tick();
    check_val(hit(w), 1'b1);
  endtask : wait_for

  // Expected fetch results worked out from the instruction inputs
  function automatic logic [15:0] fetched();
    if (pc[14:1] == 14'h0000) fetched = pc[0] ? accB : accA;
    else fetched = word;
  endfunction : fetched

  task automatic new_stimulus(input int k);
    r = $random(seed);
    pc = (k < 2) ? k[15:0] : r[15:0];
    delay = r[18:16];
    skipTest = r[19];
    r = $random(seed);
    word = r[15:0];
    if (k % 3 == 2) word[14:12] = 3'h0;
    accA = r[31:16];
    accB = ~r[31:16];
    intReq = (k % 7 == 3);
    cntIo = 0;
    cntSr = 0;
    cntAs = 0;
  endtask : new_stimulus

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Watchdog sized well above thirty instruction cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end

  // Load microcode under reset, then run instructions one after another
  initial begin
    expSc = 16'h0000;
    new_stimulus(0);
    for (int a = 0; a < 9; a++) begin
      tick();
      loadEn = 1'b1;
      loadAddr = romA[a];
      loadData = romD[a];
    end
    tick();
    loadEn = 1'b0;
    check_val(upc, mps_pkg::FETCH_ADDR0);
    check_val(phase, mps_pkg::PH_FETCH);
    check_val(instrReg, mps_pkg::WORD16_RESET);
    rst_b = 1'b1;
    for (int k = 0; k < 30; k++) begin
      wait_for(0);
      check_val(memAddr, pc);
      check_val(abAddr, (pc[14:1] == 14'h0000));
      check_val(execWord, mps_pkg::FETCH_WORD0);
      check_val(upc, mps_pkg::FETCH_ADDR1);
      tick();
      tick();
      check_val(stalled, 1'b1);
      check_val(upc, mps_pkg::FETCH_ADDR1);
      expIr = fetched();
      wait_for(1);
      check_val(instrReg, expIr);
      if (expIr[14:12] != 3'h0) expSc = {pc[15:10], expIr[9:0]};
      if (intReq) expPh = mps_pkg::PH_INTR;
      else if (expIr[14:12] != 3'h0 && expIr[15]) expPh = mps_pkg::PH_INDIR;
      else expPh = mps_pkg::PH_EXEC;
      wait_for(2);
      check_val(phase, expPh);
      check_val(scratchOne, expSc);
      intReq = 1'b0;
      wait_for(3);
      check_val(upc, mps_pkg::FETCH_ADDR0);
      check_val(cntIo, 1);
      check_val(cntSr, 1);
      check_val(cntAs, 1);
      $display("test %0d done pc=%h ir=%h", k, pc, expIr);
      new_stimulus(k + 1);
    end
    print_verdict();
  end
endmodule : test_microprogram_phase_sequencer
`default_nettype wire
